// ---- rtl/rau_map.svh ----
`ifndef RAU_MAP_SVH
`define RAU_MAP_SVH
`define RAU_EXP_W 11
`define RAU_FRAC_W 52
`define RAU_RES_W 18
`define RAU_SLOPE_W 8
`define RAU_ENT_W 26
`define RAU_IDX_HI 51
`define RAU_IDX_LO 44
`define RAU_LOC_HI 43
`define RAU_LOC_LO 36
`define RAU_ROM_ROWS 32
`define RAU_ROM_COLS 208
`define RAU_ROM_WAYS 8
`define RAU_SLOPE_SHIFT 6
`define RAU_EXP_ZERO 11'h000
`define RAU_EXP_MIN 11'h001
`define RAU_EXP_INC 11'h002
`define RAU_FRAC_MAX 18'h3FFFF
`define RAU_FU_LAT 3
`define RAU_DIV_CYC 18
`define RAU_VEC_CYC 6
`endif

// ---- rtl/rau_pkg.sv ----
`include "rau_map.svh"
package rau_pkg;
  typedef logic [`RAU_EXP_W-1:0] rau_exp_t;
  typedef logic [`RAU_RES_W-1:0] rau_res_t;
  typedef logic [`RAU_SLOPE_W-1:0] rau_slope_t;
  typedef logic [`RAU_ENT_W-1:0] rau_ent_t;

  // 2^26/(256+i) is 2^18 times 1/x at the left edge of segment i
  function automatic int rau_raw(input int i);
    return 67108864 / (256 + i);
  endfunction

  function automatic rau_res_t rau_base(input logic [7:0] idx);
    int b;
    b = rau_raw(int'(idx));
    if (b > 262143) b = 262143;
    return rau_res_t'(b);
  endfunction

  // slope is the segment drop in quarter units, the mac rescales it
  function automatic rau_slope_t rau_slope(input logic [7:0] idx);
    int s;
    s = (rau_raw(int'(idx)) - rau_raw(int'(idx) + 1)) / 4;
    if (s > 255) s = 255;
    return rau_slope_t'(s);
  endfunction
endpackage

// ---- rtl/rau_rom.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rau_map.svh"
module rau_rom (
  // lookup
  input wire logic [7:0] idx_i,
  output logic [`RAU_RES_W-1:0] base_o,
  output logic [`RAU_SLOPE_W-1:0] slope_o
);
  logic [`RAU_ROM_COLS-1:0] row_w [`RAU_ROM_ROWS];
  logic [`RAU_ROM_COLS-1:0] sel_row;
  logic [`RAU_ENT_W-1:0] ent;

  // bit b of entry k sits in column 8*b+k so one row feeds eight-way column muxes
  for (genvar r = 0; r < `RAU_ROM_ROWS; r++) begin : g_row
    for (genvar k = 0; k < `RAU_ROM_WAYS; k++) begin : g_way
      localparam logic [7:0] IDX = 8'(r * `RAU_ROM_WAYS + k);
      localparam logic [`RAU_ENT_W-1:0] ENT = {rau_pkg::rau_base(IDX), rau_pkg::rau_slope(IDX)};
      for (genvar b = 0; b < `RAU_ENT_W; b++) begin : g_bit
        assign row_w[r][b*`RAU_ROM_WAYS+k] = ENT[b];
      end
    end
  end

  assign sel_row = row_w[idx_i[7:3]];

  for (genvar b = 0; b < `RAU_ENT_W; b++) begin : g_mux
    assign ent[b] = sel_row[b*`RAU_ROM_WAYS + int'(idx_i[2:0])];
  end

  assign base_o = ent[`RAU_ENT_W-1:`RAU_SLOPE_W];
  assign slope_o = ent[`RAU_SLOPE_W-1:0];
endmodule
`default_nettype wire

// ---- rtl/rau_mac.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rau_map.svh"
module rau_mac (
  // segment data
  input wire logic [`RAU_RES_W-1:0] base_i,
  input wire logic [`RAU_SLOPE_W-1:0] slope_i,
  input wire logic [7:0] local_i,
  // interpolated fraction
  output logic [`RAU_RES_W-1:0] sum_o
);
  logic [15:0] prod;
  logic [`RAU_RES_W-1:0] term;

  assign prod = slope_i * local_i;
  // reciprocal falls across a segment, so the scaled term is added negated
  assign term = `RAU_RES_W'(~{8'h00, prod[15:`RAU_SLOPE_SHIFT]}) + 18'h00001;
  assign sum_o = base_i + term;
endmodule
`default_nettype wire

// ---- rtl/rau_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rau_map.svh"
module rau_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // divisor from the source bus
  input wire logic op_valid_i,
  input wire logic op_sign_i,
  input wire logic [`RAU_EXP_W-1:0] op_exp_i,
  input wire logic [`RAU_FRAC_W-1:0] op_frac_i,
  // seed onto the result bus
  output logic res_valid_o,
  output logic res_sign_o,
  output logic [`RAU_EXP_W-1:0] res_exp_o,
  output logic [`RAU_RES_W-1:0] res_frac_o,
  output logic res_ovf_o
);

  // cycle one: operand latched
  logic s1_vld_ff;
  logic s1_sign_ff;
  logic [7:0] s1_idx_ff;
  logic [7:0] s1_loc_ff;
  rau_pkg::rau_exp_t s1_exp_ff;
  logic s1_half_ff;

  // cycle one end: table and exponent results
  logic s2_vld_ff;
  logic s2_sign_ff;
  rau_pkg::rau_res_t s2_base_ff;
  rau_pkg::rau_slope_t s2_slope_ff;
  logic [7:0] s2_loc_ff;
  rau_pkg::rau_exp_t s2_exp_ff;
  logic s2_ovf_ff;
  logic s2_half_ff;

  // cycle two end: final sum
  logic s3_vld_ff;
  logic s3_sign_ff;
  rau_pkg::rau_res_t s3_frac_ff;
  rau_pkg::rau_exp_t s3_exp_ff;
  logic s3_ovf_ff;

  // result register
  logic res_vld_ff;
  logic res_sign_ff;
  rau_pkg::rau_res_t res_frac_ff;
  rau_pkg::rau_exp_t res_exp_ff;
  logic res_ovf_ff;

  // combinational next values
  rau_pkg::rau_res_t rom_base;
  rau_pkg::rau_slope_t rom_slope;
  rau_pkg::rau_res_t mac_sum;
  rau_pkg::rau_exp_t nxt_exp;
  logic nxt_ovf;
  rau_pkg::rau_res_t nxt_frac;

  // valid travels one stage per cycle; a new operand may enter every cycle,
  // which is what lets a vector divide overlap with the multiplier
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_vld_ff <= 1'b0;
      s2_vld_ff <= 1'b0;
      s3_vld_ff <= 1'b0;
      res_vld_ff <= 1'b0;
    end else begin
      s1_vld_ff <= op_valid_i;
      s2_vld_ff <= s1_vld_ff;
      s3_vld_ff <= s2_vld_ff;
      res_vld_ff <= s3_vld_ff;
    end
  end

  // operand capture
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_sign_ff <= 1'b0;
      s1_idx_ff <= 8'h00;
      s1_loc_ff <= 8'h00;
      s1_exp_ff <= `RAU_EXP_ZERO;
      s1_half_ff <= 1'b0;
    end else begin
      s1_sign_ff <= op_sign_i;
      s1_idx_ff <= op_frac_i[`RAU_IDX_HI:`RAU_IDX_LO];
      s1_loc_ff <= op_frac_i[`RAU_LOC_HI:`RAU_LOC_LO];
      s1_exp_ff <= op_exp_i;
      // exactly one half means every stored fraction bit is zero
      s1_half_ff <= (op_frac_i == `RAU_FRAC_W'(0));
    end
  end

  rau_rom u_rom (
    .idx_i(s1_idx_ff),
    .base_o(rom_base),
    .slope_o(rom_slope)
  );

  // negate, then one more for normalization into the half-to-one range
  assign nxt_exp = ~s1_exp_ff + `RAU_EXP_INC;
  // zero is a divide by zero; the minimum would wrap when negated
  assign nxt_ovf = (s1_exp_ff == `RAU_EXP_ZERO) || (s1_exp_ff == `RAU_EXP_MIN);

  // table read and exponent work finish within cycle one
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s2_sign_ff <= 1'b0;
      s2_base_ff <= `RAU_RES_W'(0);
      s2_slope_ff <= `RAU_SLOPE_W'(0);
      s2_loc_ff <= 8'h00;
      s2_half_ff <= 1'b0;
    end else begin
      s2_sign_ff <= s1_sign_ff;
      s2_base_ff <= rom_base;
      s2_slope_ff <= rom_slope;
      s2_loc_ff <= s1_loc_ff;
      s2_half_ff <= s1_half_ff;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s2_exp_ff <= `RAU_EXP_ZERO;
      s2_ovf_ff <= 1'b0;
    end else begin
      s2_exp_ff <= nxt_exp;
      // gated by valid so a stale or idle-bus exponent never raises the flag alone
      s2_ovf_ff <= s1_vld_ff && nxt_ovf;
    end
  end

  rau_mac u_mac (
    .base_i(s2_base_ff),
    .slope_i(s2_slope_ff),
    .local_i(s2_loc_ff),
    .sum_o(mac_sum)
  );

  // a seed of exactly one would need a one-bit renormalization downstream
  assign nxt_frac = s2_half_ff ? `RAU_FRAC_MAX : mac_sum;

  // cycle two: final sum
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s3_sign_ff <= 1'b0;
      s3_frac_ff <= `RAU_RES_W'(0);
      s3_exp_ff <= `RAU_EXP_ZERO;
      s3_ovf_ff <= 1'b0;
    end else begin
      s3_sign_ff <= s2_sign_ff;
      s3_frac_ff <= nxt_frac;
      s3_exp_ff <= s2_exp_ff;
      s3_ovf_ff <= s2_ovf_ff;
    end
  end

  // cycle three only holds, so the seed lands on the shared three-cycle slot
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res_sign_ff <= 1'b0;
      res_frac_ff <= `RAU_RES_W'(0);
      res_exp_ff <= `RAU_EXP_ZERO;
      res_ovf_ff <= 1'b0;
    end else begin
      res_sign_ff <= s3_sign_ff;
      res_frac_ff <= s3_frac_ff;
      res_exp_ff <= s3_exp_ff;
      res_ovf_ff <= s3_ovf_ff;
    end
  end

  assign res_valid_o = res_vld_ff;
  assign res_sign_o = res_sign_ff;
  assign res_frac_o = res_frac_ff;
  assign res_exp_o = res_exp_ff;
  assign res_ovf_o = res_ovf_ff;

  // checks

  sequence seq_issue;
    op_valid_i;
  endsequence

  sequence seq_table_step;
    s1_vld_ff ##1 s2_vld_ff;
  endsequence

  sequence seq_sum_step;
    s3_vld_ff;
  endsequence

  sequence seq_drive;
    res_valid_o;
  endsequence

  property p_pipe_walk;
    @(posedge clock_i) disable iff (!reset_n_i)
      seq_issue |-> ##1 seq_table_step ##1 seq_sum_step ##1 seq_drive;
  endproperty

  chk_stage_order: assert property (p_pipe_walk)
    else $error("operand did not walk the stages in order");

  chk_result_slot: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      res_valid_o |-> $past(op_valid_i, 4))
    else $error("result driven without an operand four edges before");

  chk_seed_normal: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      res_valid_o |-> res_frac_o[`RAU_RES_W-1])
    else $error("seed fraction below one half");

  chk_table_read: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      s2_vld_ff |-> (s2_base_ff == rau_pkg::rau_base($past(s1_idx_ff)))
        && (s2_slope_ff == rau_pkg::rau_slope($past(s1_idx_ff))))
    else $error("table entry does not match its index");

  chk_rom_layout: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      s1_vld_ff |-> (rom_base == rau_pkg::rau_base(s1_idx_ff))
        && (rom_slope == rau_pkg::rau_slope(s1_idx_ff)))
    else $error("interleaved table row selects the wrong entry");

  chk_interp_sum: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      (s3_vld_ff && !$past(s2_half_ff)) |->
        s3_frac_ff == $past(s2_base_ff)
          - `RAU_RES_W'((16'($past(s2_slope_ff)) * 16'($past(s2_loc_ff))) >> `RAU_SLOPE_SHIFT))
    else $error("interpolated fraction wrong");

  chk_exp_negate: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      res_valid_o |-> res_exp_o == rau_pkg::rau_exp_t'(~$past(op_exp_i, 4) + `RAU_EXP_INC))
    else $error("result exponent is not negated plus one");

  chk_half_clamp: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      (op_valid_i && (op_frac_i == `RAU_FRAC_W'(0))) |->
        ##4 (res_valid_o && res_frac_o == `RAU_FRAC_MAX))
    else $error("one half input did not clamp below one");

  chk_zero_ovf: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      (op_valid_i && op_exp_i == `RAU_EXP_ZERO) |-> ##4 res_ovf_o)
    else $error("zero exponent missed overflow");

  chk_min_ovf: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      res_valid_o |-> res_ovf_o == (($past(op_exp_i, 4) == `RAU_EXP_MIN)
        || ($past(op_exp_i, 4) == `RAU_EXP_ZERO)))
    else $error("overflow flag wrong for the exponent");

  chk_ovf_align: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      res_ovf_o |-> res_valid_o)
    else $error("overflow appeared away from its result");

  chk_back_to_back: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      op_valid_i [*2] |-> ##3 res_valid_o [*2])
    else $error("pipeline dropped a consecutive operand");

  chk_div_budget: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      seq_issue |-> ##4 (res_valid_o && (`RAU_DIV_CYC == 6 * `RAU_FU_LAT)))
    else $error("seed does not fit the divide schedule");

endmodule
`default_nettype wire

// ---- test/rau_src_bus.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rau_map.svh"
module rau_src_bus (
  // clock
  input wire logic clock_i,
  // source bus
  output logic op_valid_o,
  output logic op_sign_o,
  output logic [`RAU_EXP_W-1:0] op_exp_o,
  output logic [`RAU_FRAC_W-1:0] op_frac_o,
  // result bus, packed as sign, exponent, fraction, overflow
  input wire logic res_valid_i,
  input wire logic [30:0] res_word_i
);
  int cyc = 0;
  int take_q[$];
  int got_q[$];
  logic [30:0] word_q[$];
  initial begin
    op_valid_o = 1'b0;
    op_sign_o = 1'b0;
    op_exp_o = '0;
    op_frac_o = '0;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (op_valid_o === 1'b1) begin
      take_q.push_back(cyc);
    end
    if (res_valid_i === 1'b1) begin
      got_q.push_back(cyc);
      word_q.push_back(res_word_i);
    end
  end
  // back-to-back calls keep valid high, one operand per cycle
  task automatic put(input logic s, input logic [10:0] e, input logic [51:0] f);
    @(posedge clock_i);
    op_valid_o <= 1'b1;
    op_sign_o <= s;
    op_exp_o <= e;
    op_frac_o <= f;
  endtask
  // a released bus shows the inverse, so a stale operand cannot pass as held
  task automatic idle();
    @(posedge clock_i);
    op_valid_o <= 1'b0;
    op_sign_o <= ~op_sign_o;
    op_exp_o <= ~op_exp_o;
    op_frac_o <= ~op_frac_o;
  endtask
  task automatic clear();
    take_q.delete();
    got_q.delete();
    word_q.delete();
  endtask
endmodule
`default_nettype wire

// ---- test/rau_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rau_map.svh"
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("BAD %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module rau_top_bench;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  int err_count = 0;
  int n_checks = 0;
  logic op_valid;
  logic op_sign;
  logic [10:0] op_exp;
  logic [51:0] op_frac;
  logic res_valid;
  logic res_sign;
  logic [10:0] res_exp;
  logic [17:0] res_frac;
  logic res_ovf;
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  rau_top dut (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .op_valid_i(op_valid),
    .op_sign_i(op_sign),
    .op_exp_i(op_exp),
    .op_frac_i(op_frac),
    .res_valid_o(res_valid),
    .res_sign_o(res_sign),
    .res_exp_o(res_exp),
    .res_frac_o(res_frac),
    .res_ovf_o(res_ovf)
  );
  rau_src_bus src (
    .clock_i(clock_i),
    .op_valid_o(op_valid),
    .op_sign_o(op_sign),
    .op_exp_o(op_exp),
    .op_frac_o(op_frac),
    .res_valid_i(res_valid),
    .res_word_i({res_sign, res_exp, res_frac, res_ovf})
  );
  function automatic int seg_raw(input int i);
    return 67108864 / (256 + i);
  endfunction
  function automatic logic [30:0] expect_word(input logic [63:0] op);
    int i;
    int l;
    int b;
    int sl;
    logic [17:0] fr;
    i = int'(op[51:44]);
    l = int'(op[43:36]);
    b = (seg_raw(i) > 262143) ? 262143 : seg_raw(i);
    sl = (seg_raw(i) - seg_raw(i + 1)) / 4;
    if (sl > 255) begin
      sl = 255;
    end
    fr = 18'(b - ((sl * l) >> 6));
    return {op[63], 11'(~op[62:52] + 11'h002), fr, op[62:52] == 11'h000 || op[62:52] == 11'h001};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic run_ops(input logic [63:0] ops[$], input string name);
    int k;
    src.clear();
    foreach (ops[j]) src.put(ops[j][63], ops[j][62:52], ops[j][51:0]);
    src.idle();
    k = 0;
    while (src.got_q.size() < ops.size() && k < 20) begin
      @(posedge clock_i);
      k++;
    end
    if (src.got_q.size() < ops.size()) begin
      $display("BAD result wait expected %0d seen %0d", ops.size(), src.got_q.size());
      err_count++;
      report_and_stop();
    end
    repeat (4) @(posedge clock_i);
    `CHK("result count", ops.size(), src.got_q.size())
    for (int j = 0; j < ops.size() && j < src.got_q.size(); j++) begin
      `CHK(name, expect_word(ops[j]), src.word_q[j])
      `CHK("latency", src.take_q[j] + `RAU_FU_LAT + 1, src.got_q[j])
    end
    $display("test %s done", name);
  endtask
  // every table entry, streamed with no gaps, low fraction bits set to be ignored
  task automatic t_stream();
    logic [63:0] ops[$];
    real x;
    real d;
    for (int k = 0; k < 256; k++) begin
      ops.push_back({k[0], 11'(k * 9), 8'(k), 8'(k * 7) ^ 8'h5A, 36'hFFFFFFFFF});
    end
    run_ops(ops, "stream");
    for (int j = 0; j < src.word_q.size(); j++) begin
      x = 1.0 + real'(ops[j][51:36]) / 65536.0;
      d = real'(src.word_q[j][18:1]) - 262144.0 / x;
      `CHK("accuracy", 1'b1, logic'(d <= 4.0 && d >= -4.0))
    end
  endtask
  task automatic t_edges();
    logic [63:0] ops[$];
    ops = '{{1'b0, 11'h400, 52'h0}, {1'b1, 11'h000, 52'h8000000000000},
            {1'b0, 11'h001, 52'hFFFFFFFFFFFFF}, {1'b1, 11'h002, 52'h1},
            {1'b0, 11'h7FF, 52'h0}};
    run_ops(ops, "edges");
    `CHK("half frac", 18'h3FFFF, src.word_q[0][18:1])
    `CHK("half exp", 11'h401, src.word_q[0][29:19])
    `CHK("zero exp ovf", 1'b1, src.word_q[1][0])
    `CHK("min exp ovf", 1'b1, src.word_q[2][0])
    `CHK("exp 2 ovf", 1'b0, src.word_q[3][0])
    `CHK("exp 2 result", 11'h7FF, src.word_q[3][29:19])
  endtask
  // a reset in flight must swallow the pending result
  task automatic t_reset_mid();
    src.clear();
    src.put(1'b1, 11'h123, 52'hFFFFFFFFFFFFF);
    src.idle();
    reset_n_i <= 1'b0;
    @(posedge clock_i);
    #1;
    `CHK("valid in reset", 1'b0, res_valid)
    `CHK("frac in reset", 18'h0, res_frac)
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    `CHK("results after reset", 0, src.got_q.size())
    $display("test reset_mid done");
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    `CHK("valid held in reset", 1'b0, res_valid)
    reset_n_i <= 1'b1;
    t_stream();
    t_edges();
    t_reset_mid();
    report_and_stop();
  end
endmodule
`default_nettype wire
